/* rtl/spi_port_pkg.sv */
// constants and types shared by the serial port and its helpers
// assumes a 100 MHz system clock and an apb master on the same clock
package spi_port_pkg;

    // system clock period
    localparam int CLK_PERIOD_NS = 10;

    // register byte addresses (one aligned 32-bit word each)
    localparam logic [31:0] ADDR_STATUS = 32'hffff_0a00;
    localparam logic [31:0] ADDR_RX = 32'hffff_0a04;
    localparam logic [31:0] ADDR_TX = 32'hffff_0a08;
    localparam logic [31:0] ADDR_DIV = 32'hffff_0a0c;
    localparam logic [31:0] ADDR_CON = 32'hffff_0a10;

    // reset values
    localparam logic [15:0] CON_RESET = 16'h0000;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // writable control bits: 15..13 and 4 are reserved
    localparam logic [15:0] CON_WR_MASK = 16'h1fef;

    // control field positions
    localparam int CON_EN = 0;
    localparam int CON_MASTER = 1;
    localparam int CON_CPHA = 2;
    localparam int CON_CPOL = 3;
    localparam int CON_LSB = 5;
    localparam int CON_UNF_MODE = 7;
    localparam int CON_OVW = 8;
    localparam int CON_SS_OE = 9;
    localparam int CON_SLV_OE = 10;
    localparam int CON_LOOP = 11;
    localparam int CON_CONT = 12;

    // status field positions
    localparam int STA_TX_FULL = 0;
    localparam int STA_TX_IRQ = 1;
    localparam int STA_TX_UNF = 2;
    localparam int STA_RX_FULL = 3;
    localparam int STA_RX_IRQ = 4;
    localparam int STA_RX_OVF = 5;

    // highest core clock divider setting at which the port works
    localparam logic [2:0] CORE_DIV_MAX_OK = 3'h1;
    // eight bits give sixteen serial clock edges per byte
    localparam logic [3:0] LAST_EDGE = 4'hf;

    // gap between single-byte master transfers
    localparam int STALL_NS = 80;
    localparam int STALL_CYCLES = (STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STALL_LAST = 8'(STALL_CYCLES - 1);

    // master sequencer
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_SHIFT = 2'b01,
        M_STALL = 2'b11
    } xfer_state_t;

endpackage

/* rtl/spi_sync2.sv */
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous levels; output lags by two clocks
`timescale 1ns/10ps
module spi_sync2 #(
    parameter int W = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    input wire logic [W-1:0] reset_val_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta; // first stage, read only by the second
        logic [W-1:0] sync; // second stage
    } sync_state_t;

    sync_state_t q;
    sync_state_t s;

    // shift pin levels through both stages
    always_comb begin
        s = q;
        s.meta = async_i;
        s.sync = q.meta;
    end

    // reset loads the pin idle levels: no false edge
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= {reset_val_i, reset_val_i};
        end else begin
            q <= s;
        end
    end

    assign sync_o = q.sync;
endmodule // spi_sync2

/* rtl/spi_baud_tick.sv */
// half-period tick generator for master serial clock
// assumes div_i is stable while run_i is high
`timescale 1ns/10ps
module spi_baud_tick (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [7:0] div_i,
    output logic tick_o
);
    typedef struct packed {
        logic [7:0] cnt; // cycles into the current half period
        logic tick; // one-cycle pulse per half period
    } tick_state_t;

    tick_state_t q;
    tick_state_t s;

    // one tick every div+1 clocks, so a full clock is 2*(1+div)
    always_comb begin
        s = q;
        s.tick = 1'b0;
        if (!run_i) begin
            s.cnt = 8'h00; // restart so the first half period is full length
        end else if (q.cnt == div_i) begin
            s.cnt = 8'h00;
            s.tick = 1'b1;
        end else begin
            s.cnt = q.cnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= s;
        end
    end

    assign tick_o = q.tick;
endmodule // spi_baud_tick

/* rtl/spi_master_slave_port.sv */
// byte-wide full-duplex serial port, master or slave, behind an apb slave
// assumes apb on sys_clk_i; serial pins are asynchronous and are synchronised here
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
//
// Overview of operation
// - eight bits out and in simultaneously
// - works only at core divider 0 or 1
// - master: miso in, mosi out; slave reversed
// - one byte, msb first by default
// - one byte takes eight serial clocks
// - serial clock out in master, in in slave
// - master clock is base over 2*(1+div)
// - launch one edge, sample the other
// - slave transfer framed by low select input
// - continuous mode keeps select low while data
// - single mode: one byte, then a stall
// - loopback ties data out to data in
// - slave output enable gates miso drive
// - select pin driven only when enabled
// - 16-bit control, reset zero, top reserved
// - overwrite replaces unread data, else dropped
// - polarity selects idle level of clock
// - phase selects pulse at start or end
// - master bit picks mode, enable bit gates
module spi_master_slave_port (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [2:0] core_clk_div_i,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe_o
);
    import spi_port_pkg::*;

    typedef struct packed {
        logic [15:0] con; // control register
        logic [7:0] div; // serial clock divider
        logic [7:0] tx; // transmit holding data
        logic [7:0] last_tx; // last byte sent, replayed on underflow
        logic tx_full; // transmit holding data valid
        logic tx_unf; // slave needed data and had none
        logic [7:0] rx; // receive holding data
        logic rx_full; // receive holding data valid
        logic rx_ovf; // a byte arrived while rx was unread
        xfer_state_t st; // master sequencer
        logic [7:0] shift; // shift register, msb goes out
        logic samp; // bit sampled, waits for the shift edge
        logic [3:0] edge_cnt; // serial clock edges into the byte
        logic [7:0] stall_cnt; // cycles into the stall gap
        logic sclk_prev; // last synchronised slave clock level
        logic ss_prev; // last synchronised select level
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic sclk;
        logic mosi;
        logic miso;
        logic ss_n;
        logic sclk_oe;
        logic mosi_oe;
        logic miso_oe;
        logic ss_oe;
    } port_state_t;

    port_state_t q; // registered state
    port_state_t s; // next state

    logic [3:0] pins_s; // synchronised sclk, mosi, miso, select
    logic sclk_s;
    logic mosi_s;
    logic miso_s;
    logic ss_s;
    logic tick; // master half-period pulse
    logic baud_run;

    // reverse bit order, used for lsb-first send and receive
    function automatic logic [7:0] bit_order(input logic [7:0] d, input logic lsb);
        logic [7:0] r;
        r = d;
        if (lsb) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = d[7 - i];
            end
        end
        return r;
    endfunction

    // address decode: true for any mapped register
    function automatic logic addr_hit(input logic [31:0] a);
        return (a == ADDR_STATUS) || (a == ADDR_RX) || (a == ADDR_TX) ||
               (a == ADDR_DIV) || (a == ADDR_CON);
    endfunction

    // pins arrive from outside the clock domain
    spi_sync2 #(
        .W(4)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({sclk_i, mosi_i, miso_i, ss_n_i}),
        .reset_val_i(4'h1),
        .sync_o(pins_s)
    );

    assign sclk_s = pins_s[3];
    assign mosi_s = pins_s[2];
    assign miso_s = pins_s[1];
    assign ss_s = pins_s[0];

    // divider only runs while the master is shifting
    assign baud_run = (q.st == M_SHIFT);

    spi_baud_tick u_baud (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(baud_run),
        .div_i(q.div),
        .tick_o(tick)
    );

    // whole next-state: bus, sequencer, shifter, pin drive
    always_comb begin
        logic functional;
        logic master;
        logic cpha;
        logic lsb;
        logic access;
        logic done;
        logic edge_ev;
        logic sample_in;
        logic byte_done;
        logic slave_start;
        logic load;
        logic [7:0] rx_byte;
        functional = 1'b0;
        master = 1'b0;
        cpha = 1'b0;
        lsb = 1'b0;
        access = 1'b0;
        done = 1'b0;
        edge_ev = 1'b0;
        sample_in = 1'b0;
        byte_done = 1'b0;
        slave_start = 1'b0;
        load = 1'b0;
        rx_byte = 8'h00;
        s = q;

        functional = q.con[CON_EN] && (core_clk_div_i <= CORE_DIV_MAX_OK);
        master = q.con[CON_MASTER];
        cpha = q.con[CON_CPHA];
        lsb = q.con[CON_LSB];

        // apb: ready one cycle into the access phase, effects at that edge
        access = psel_i && penable_i;
        done = access && q.pready;
        s.pready = access && !q.pready;
        s.pslverr = access && !q.pready && !addr_hit(paddr_i);
        s.prdata = 32'h0000_0000;
        if (access && !q.pready && !pwrite_i) begin
            unique case (paddr_i)
                ADDR_STATUS: begin
                    s.prdata[STA_TX_FULL] = q.tx_full;
                    s.prdata[STA_TX_IRQ] = !q.tx_full || q.tx_unf;
                    s.prdata[STA_TX_UNF] = q.tx_unf;
                    s.prdata[STA_RX_FULL] = q.rx_full;
                    s.prdata[STA_RX_IRQ] = q.rx_full || q.rx_ovf;
                    s.prdata[STA_RX_OVF] = q.rx_ovf;
                end
                ADDR_RX: s.prdata[7:0] = q.rx;
                ADDR_DIV: s.prdata[7:0] = q.div;
                ADDR_CON: s.prdata[15:0] = q.con;
                default: s.prdata = 32'h0000_0000; // tx is write-only, unmapped reads zero
            endcase
        end
        // reading rx clears its flags; a byte landing this cycle sets rx_full again below, rx_ovf stays clear
        if (done && !pwrite_i && (paddr_i == ADDR_RX)) begin
            s.rx_full = 1'b0;
            s.rx_ovf = 1'b0;
        end

        s.sclk_prev = sclk_s;
        s.ss_prev = ss_s;

        // serial clock edge: tick in master, pin transition in slave
        if (master) begin
            edge_ev = (q.st == M_SHIFT) && tick;
        end else begin
            edge_ev = functional && !ss_s && !q.ss_prev && (sclk_s != q.sclk_prev);
        end
        // data in: pins per mode, or own data out in loopback
        if (q.con[CON_LOOP]) begin
            sample_in = master ? q.mosi : q.miso;
        end else begin
            sample_in = master ? miso_s : mosi_s;
        end

        // sample on one edge, shift on the other; phase picks which
        if (edge_ev) begin
            if (master) begin
                s.sclk = !q.sclk;
            end
            if (q.edge_cnt[0] == cpha) begin
                s.samp = sample_in;
            end else if (!(cpha && (q.edge_cnt == 4'h0))) begin
                s.shift = {q.shift[6:0], q.samp};
            end
            s.edge_cnt = q.edge_cnt + 4'h1;
            byte_done = (q.edge_cnt == LAST_EDGE);
        end

        // store a finished byte, honouring overwrite mode
        if (byte_done) begin
            rx_byte = cpha ? {s.shift[6:0], s.samp} : s.shift;
            if (!s.rx_full || q.con[CON_OVW]) begin
                s.rx = bit_order(rx_byte, lsb);
            end
            if (s.rx_full) begin
                s.rx_ovf = 1'b1;
            end
            s.rx_full = 1'b1;
            s.edge_cnt = 4'h0;
        end

        // slave framing: select fall starts, select high discards the partial byte
        slave_start = functional && !master && !ss_s && q.ss_prev;
        if (!master && ss_s) begin
            s.edge_cnt = 4'h0;
        end
        if (!master && (slave_start || (byte_done && !ss_s))) begin
            load = 1'b1;
        end

        // master sequencer
        unique case (q.st)
            M_IDLE: begin
                s.sclk = q.con[CON_CPOL];
                s.ss_n = 1'b1;
                if (functional && master && q.tx_full) begin
                    load = 1'b1;
                    s.st = M_SHIFT;
                    s.ss_n = 1'b0;
                    s.edge_cnt = 4'h0;
                end
            end
            M_SHIFT: begin
                if (byte_done) begin
                    if (q.con[CON_CONT] && q.tx_full) begin
                        load = 1'b1;
                    end else if (q.con[CON_CONT]) begin
                        s.st = M_IDLE;
                        s.ss_n = 1'b1;
                    end else begin
                        s.st = M_STALL;
                        s.ss_n = 1'b1;
                        s.stall_cnt = 8'h00;
                    end
                end
            end
            M_STALL: begin
                s.stall_cnt = q.stall_cnt + 8'h01;
                if (q.stall_cnt == STALL_LAST) begin
                    s.st = M_IDLE;
                end
            end
            default: s.st = M_IDLE;
        endcase
        // leaving master mode or losing enable aborts a byte
        if (!(functional && master) && (q.st != M_IDLE)) begin
            s.st = M_IDLE;
            s.ss_n = 1'b1;
            s.sclk = q.con[CON_CPOL];
            s.edge_cnt = 4'h0;
        end

        // next byte into the shifter; underflow replays or sends zero
        if (load) begin
            if (q.tx_full) begin
                s.shift = bit_order(q.tx, lsb);
                s.last_tx = q.tx;
                s.tx_full = 1'b0;
            end else begin
                s.shift = bit_order(q.con[CON_UNF_MODE] ? q.last_tx : DATA_RESET, lsb);
                s.tx_unf = 1'b1;
            end
        end

        // bus writes last, so a write in the load cycle is kept
        if (done && pwrite_i) begin
            unique case (paddr_i)
                ADDR_CON: s.con = pwdata_i[15:0] & CON_WR_MASK;
                ADDR_DIV: s.div = pwdata_i[7:0];
                ADDR_TX: begin
                    s.tx = pwdata_i[7:0];
                    s.tx_full = 1'b1;
                    s.tx_unf = load && !q.tx_full; // underflow set wins
                end
                default: s.tx_unf = s.tx_unf; // read-only or unmapped: ignored
            endcase
        end

        // pin drive; data lines follow the shifter msb
        s.mosi = s.shift[7];
        s.miso = s.shift[7];
        s.sclk_oe = functional && master;
        s.mosi_oe = functional && master;
        s.ss_oe = functional && master && q.con[CON_SS_OE];
        s.miso_oe = functional && !master && q.con[CON_SLV_OE] && !ss_s;
    end

    // single register for all state; synchronous reset
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.con <= CON_RESET;
            q.div <= DIV_RESET;
            q.ss_n <= 1'b1;
            q.sclk_prev <= 1'b0;
            q.ss_prev <= 1'b1;
        end else begin
            q <= s;
        end
    end

    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign sclk_o = q.sclk;
    assign sclk_oe_o = q.sclk_oe;
    assign mosi_o = q.mosi;
    assign mosi_oe_o = q.mosi_oe;
    assign miso_o = q.miso;
    assign miso_oe_o = q.miso_oe;
    assign ss_n_o = q.ss_n;
    assign ss_n_oe_o = q.ss_oe;
endmodule // spi_master_slave_port

/* sim/spi_port_checker.sv */
// concurrent checks on the serial port pins and the apb answer
// assumes one clock domain; control is shadowed from observed apb writes
`timescale 1ns/10ps
module spi_port_checker
    import spi_port_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic [2:0] core_clk_div_i,
    input wire logic sclk_o,
    input wire logic sclk_oe_o,
    input wire logic mosi_o,
    input wire logic mosi_oe_o,
    input wire logic miso_oe_o,
    input wire logic ss_n_o,
    input wire logic ss_n_oe_o
);
    logic [15:0] con_r; // shadow of the control register
    logic [3:0] tgl_r; // clock toggles in the frame, wraps every byte
    logic sclk_q;
    logic ss_q;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // shadow takes effect at the same edge as the device write
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            con_r <= CON_RESET;
            tgl_r <= 4'h0;
            sclk_q <= 1'b0;
            ss_q <= 1'b1;
        end else begin
            if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_CON) begin
                con_r <= pwdata_i[15:0] & CON_WR_MASK;
            end
            sclk_q <= sclk_o;
            ss_q <= ss_n_o;
            // count toggles including the one at the closing edge
            if (ss_n_o && ss_q) begin
                tgl_r <= 4'h0;
            end else if (sclk_o != sclk_q) begin
                tgl_r <= tgl_r + 4'h1;
            end
        end
    end
    a_ready_delay: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("apb answer not one cycle after access");
    a_con_read: assert property (psel_i && penable_i && pready_o && !pwrite_i && paddr_i == ADDR_CON
        |-> prdata_o == {16'h0000, con_r})
        else $error("control readback wrong");
    a_ss_drive: assert property (ss_n_oe_o |-> $past(con_r[CON_MASTER] && con_r[CON_SS_OE]))
        else $error("select driven without enable");
    a_master_pins: assert property ({sclk_oe_o, mosi_oe_o} == {2{$past(con_r[CON_EN] && con_r[CON_MASTER]
        && core_clk_div_i <= CORE_DIV_MAX_OK)}})
        else $error("master pin drive wrong");
    a_miso_drive: assert property (miso_oe_o |-> !$past(con_r[CON_MASTER]) && $past(con_r[CON_SLV_OE])
        && $past(core_clk_div_i) <= CORE_DIV_MAX_OK)
        else $error("slave output driven when off");
    a_edge_count: assert property ($rose(ss_n_o) && sclk_oe_o |=> tgl_r == 4'h0)
        else $error("frame not a multiple of sixteen edges");
    a_stall_gap: assert property (!con_r[CON_CONT] && $rose(ss_n_o) && ss_n_oe_o |-> ss_n_o [*8])
        else $error("select gap too short");
    a_mosi_hold: assert property (!ss_n_o && $past(!ss_n_o) && tgl_r != 4'h0 && $stable(sclk_o)
        |-> $stable(mosi_o))
        else $error("data changed away from a clock edge");
    cover property ($rose(ss_n_o) && sclk_oe_o);
    cover property (miso_oe_o);
    cover property (pready_o && !pwrite_i && paddr_i == ADDR_CON);
endmodule // spi_port_checker

bind spi_master_slave_port spi_port_checker u_chk (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .core_clk_div_i, .sclk_o, .sclk_oe_o, .mosi_o, .mosi_oe_o,
    .miso_oe_o, .ss_n_o, .ss_n_oe_o);

/* sim/spi_slave_model.sv */
// behavioural external slave for master-mode runs, clock mode zero only
// assumes select and clock come from the port under test
`timescale 1ns/10ps
module spi_slave_model (
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic [7:0] tx_i,
    output logic miso_o,
    output logic [7:0] rx_o
);
    logic [7:0] sh_r = 8'h00; // outgoing shifter
    int nb = 0; // bits launched in this frame
    initial begin
        miso_o = 1'b0;
        rx_o = 8'h00;
    end
    // frame start puts the first bit out before any clock edge
    always @(negedge ss_n_i) begin
        sh_r = tx_i;
        nb = 0;
        miso_o = tx_i[7];
    end
    // sample on the leading edge, msb first
    always @(posedge sclk_i) if (!ss_n_i) rx_o = {rx_o[6:0], mosi_i};
    // launch on the trailing edge, reload every eight bits
    always @(negedge sclk_i) if (!ss_n_i) begin
        nb = nb + 1;
        sh_r = (nb % 8 == 0) ? tx_i : {sh_r[6:0], 1'b0};
        miso_o = sh_r[7];
    end
    // a released line shows the inverse, never a held last bit
    always @(posedge ss_n_i) miso_o = ~miso_o;
endmodule // spi_slave_model

/* sim/spi_master_slave_port_tb_top.sv */
// self-checking bench: apb master, pin resolution, slave model
// assumes the checker is bound from its own file
`timescale 1ns/10ps
module spi_master_slave_port_tb_top;
    import spi_port_pkg::*;
    localparam int DIV = 11;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [31:0] paddr_i = 32'h0000_0000, pwdata_i = 32'h0000_0000, prdata_o;
    logic [2:0] core_clk_div_i = 3'h0;
    logic pready_o, pslverr_o, sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, ss_n_o, ss_n_oe_o;
    logic tb_sclk = 1'b0, tb_mosi = 1'b0, tb_ss_n = 1'b1, mdl_miso, ss_q = 1'b1;
    logic [7:0] mdl_tx = 8'h00, mdl_rx;
    int fail_count = 0, cmp_count = 0, rises = 0;
    // each wire follows whoever drives it
    wire sclk_w = sclk_oe_o ? sclk_o : tb_sclk;
    wire mosi_w = mosi_oe_o ? mosi_o : tb_mosi;
    wire miso_w = miso_oe_o ? miso_o : mdl_miso;
    wire ss_w = ss_n_oe_o ? ss_n_o : tb_ss_n;
    always #5 sys_clk_i = ~sys_clk_i;
    // count select releases to tell frames apart
    always @(posedge sys_clk_i) begin
        ss_q <= ss_n_o;
        if (ss_n_o === 1'b1 && ss_q === 1'b0) rises <= rises + 1;
    end
    spi_master_slave_port u_dut (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .core_clk_div_i, .sclk_i(sclk_w), .sclk_o, .sclk_oe_o,
        .mosi_i(mosi_w), .mosi_o, .mosi_oe_o, .miso_i(miso_w), .miso_o, .miso_oe_o, .ss_n_i(ss_w),
        .ss_n_o, .ss_n_oe_o);
    spi_slave_model u_mdl (.sclk_i(sclk_w), .ss_n_i(ss_w), .mosi_i(mosi_w), .tx_i(mdl_tx),
        .miso_o(mdl_miso), .rx_o(mdl_rx));
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        chk(32'h0000_0000, 32'h0000_0001);
        wrap_up();
    endtask
    // one apb transfer; released one edge after completion
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) tmo();
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask
    // select must stay high for twenty cycles in a row
    task automatic wait_idle;
        int n, q;
        n = 0;
        q = 0;
        while (q < 20) begin
            @(posedge sys_clk_i);
            q = (ss_n_o === 1'b1) ? q + 1 : 0;
            n++;
            if (n > 3000) tmo();
        end
    endtask
    task automatic wait_lvl(input logic v, inout int n);
        while (sclk_o !== v) begin
            @(posedge sys_clk_i);
            n++;
            if (n > 500) tmo();
        end
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rd(ADDR_CON, r);
        chk(r, 32'h0000_0000);
        wr(ADDR_CON, 32'hffff_ffff);
        rd(ADDR_CON, r);
        chk(r, 32'h0000_1fef);
        apb(1'b0, 32'hffff_0a20, 32'h0000_0000, r, e);
        chk(e, 1'b1);
        wr(ADDR_CON, 32'h0000_0000);
        wr(ADDR_DIV, DIV);
        $display("registers done");
    endtask
    task automatic t_xfer(input logic [15:0] c, input logic [7:0] tx, input logic [7:0] mtx,
        input logic [7:0] erx, input logic [7:0] emdl);
        logic [31:0] r;
        int n;
        mdl_tx <= mtx;
        wr(ADDR_CON, c);
        wr(ADDR_TX, tx);
        n = 0;
        wait_lvl(1'b1, n);
        n = 0;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        chk(n, 2 * (DIV + 1));
        wait_idle();
        rd(ADDR_RX, r);
        chk(r, erx);
        chk(mdl_rx, emdl);
        $display("transfer done");
    endtask
    task automatic t_pair(input logic [15:0] c, input int exp);
        logic [31:0] r;
        int n0, k;
        n0 = rises;
        k = 0;
        wr(ADDR_CON, c);
        wr(ADDR_TX, 32'h0000_0011);
        do begin
            rd(ADDR_STATUS, r);
            k++;
            if (k > 100) tmo();
        end while (r[STA_TX_FULL] !== 1'b0);
        wr(ADDR_TX, 32'h0000_0022);
        wait_idle();
        chk(rises - n0, exp);
        rd(ADDR_RX, r);
        $display("pair done");
    endtask
    task automatic t_ovw(input logic ow, input logic [7:0] exp);
        logic [31:0] r;
        mdl_tx <= 8'h61;
        wr(ADDR_CON, {16'h0000, 7'h01, ow, 8'h03});
        wr(ADDR_TX, 32'h0000_0000);
        wait_idle();
        mdl_tx <= 8'h62;
        wr(ADDR_TX, 32'h0000_0000);
        wait_idle();
        rd(ADDR_STATUS, r);
        chk(r[5:0], 6'h3a);
        rd(ADDR_RX, r);
        chk(r, exp);
        $display("overwrite done");
    endtask
    task automatic t_core_div;
        logic [31:0] r;
        int n0;
        n0 = rises;
        core_clk_div_i <= 3'h2;
        wr(ADDR_CON, 32'h0000_0203);
        wr(ADDR_TX, 32'h0000_0055);
        repeat (40) @(posedge sys_clk_i);
        chk(ss_n_o, 1'b1);
        chk(sclk_oe_o, 1'b0);
        core_clk_div_i <= 3'h1;
        wait_idle();
        chk(rises - n0, 1);
        rd(ADDR_RX, r);
        $display("core divider done");
    endtask
    // bench acts as external master, period of eight system clocks
    task automatic sbyte(input logic [7:0] o, input int nb, output logic [7:0] i);
        tb_ss_n <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        for (int b = 7; b > 7 - nb; b--) begin
            tb_mosi <= o[b];
            repeat (4) @(posedge sys_clk_i);
            i[b] = miso_o;
            tb_sclk <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            tb_sclk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk_i);
        tb_ss_n <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
    endtask
    task automatic t_slave;
        logic [31:0] r;
        logic [7:0] i;
        wr(ADDR_CON, 32'h0000_0401);
        wr(ADDR_TX, 32'h0000_0096);
        sbyte(8'hc3, 8, i);
        chk(i, 8'h96);
        rd(ADDR_RX, r);
        chk(r, 32'h0000_00c3);
        sbyte(8'hff, 3, i);
        sbyte(8'h5a, 8, i);
        rd(ADDR_RX, r);
        chk(r, 32'h0000_005a);
        $display("slave done");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        t_regs();
        t_xfer(16'h0203, 8'ha5, 8'h5c, 8'h5c, 8'ha5);
        t_xfer(16'h0223, 8'h01, 8'h0f, 8'hf0, 8'h80);
        t_xfer(16'h0a03, 8'h3c, 8'h99, 8'h3c, 8'h3c);
        t_pair(16'h1203, 1);
        t_pair(16'h0203, 2);
        t_ovw(1'b0, 8'h61);
        t_ovw(1'b1, 8'h62);
        t_core_div();
        t_slave();
        wrap_up();
    end
endmodule // spi_master_slave_port_tb_top
